// [core/ugc_pkg.sv]
package ugc_pkg;

  // ===========================================================
  // Register map (byte addresses)
  localparam logic [7:0] GEN_CTRL_OFS   = 8'h00;
  localparam logic [7:0] GEN_STAT_OFS   = 8'h04;
  localparam logic [7:0] GEN_IRQEN_OFS  = 8'h08;
  localparam logic [7:0] GEN_IRQCLR_OFS = 8'h0c;
  localparam logic [7:0] DEV_CTRL_OFS   = 8'h10;
  localparam logic [7:0] EP_CFG_BASE    = 8'h20;
  localparam logic [7:0] EP_STAT_BASE   = 8'h40;
  localparam logic [7:0] EP_ENA_OFS     = 8'h60;

  // ===========================================================
  // Control register fields
  localparam int CTL_PADE  = 0;
  localparam int CTL_VPOL  = 1;
  localparam int CTL_FRZ   = 2;
  localparam int CTL_EN    = 3;
  localparam int CTL_IDSEL = 4;
  localparam int CTL_SWROL = 5;
  localparam int CTL_LS    = 6;
  localparam int DEV_DISCONNECT_BIT = 0;

  // Status bits / event positions
  localparam int EV_ID    = 0;
  localparam int EV_SUP   = 1;
  localparam int EV_ROLE  = 2;
  localparam int EV_SERR  = 3;
  localparam int EV_BCERR = 4;
  localparam int EV_STO   = 5;
  localparam int EV_WAKE  = 6;
  localparam int EV_HWUP  = 7;
  localparam int EV_LINE_SUSPEND_IRQ  = 8;
  localparam int NUM_EV   = 9;
  localparam logic [NUM_EV-1:0] ASYNC_EV_MASK = 9'h0c3;

  // Endpoint config fields
  localparam int CFG_MEMORY_ALLOCATE_BIT = 0;
  localparam int CFG_BK    = 1;
  localparam int CFG_SZ_LO = 4;
  localparam int CFG_SZ_HI = 6;

  // ===========================================================
  // Reset values and buffer geometry
  localparam logic [6:0] CTL_RESET    = 7'h34;
  localparam logic       DISCONNECT_BIT_RESET = 1'b1;
  localparam logic       ROLE_IDLE    = 1'b1;
  localparam int         NUM_EP       = 7;
  localparam logic [10:0] RAM_BYTES   = 11'd960;

  typedef enum logic [2:0] {
    UGC_OFF  = 3'b001,
    UGC_DEV  = 3'b010,
    UGC_HOST = 3'b100
  } ugc_mode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ugc_req_t;

  typedef struct packed {
    logic       busSuspend;
    logic       lineResume;
    logic       hostResume;
    logic       supplyErr;
    logic       bconnErr;
    logic       suspTimeout;
    logic       roleExch;
    logic [1:0] speedDet;
  } ugc_core_ev_t;

  // Maximum byte size allowed per index
  function automatic logic [8:0] ugc_max_size(input int idx);
    return (idx >= 5) ? 9'd256 : 9'd64;
  endfunction

  // Byte size selected by a 3-bit size code (8 << code)
  function automatic logic [10:0] ugc_size_bytes(input logic [2:0] code);
    return 11'd8 << code;
  endfunction

endpackage

// [core/ugc_general_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// - Disabled after reset; enabled, role follows the role identification pin.
// - Role pin high reads one, device role; pin low clears it, host role.
// - In reset: enable zero, freeze set, pad suspended, buffer RAM kept.
// - Pad, polarity, freeze, enable, pin select, role, low speed writable when off.
// - Enable written one enters device or host role in its idle state.
// - Writing enable zero resets endpoint, attach, speed state; control bits, interrupt enables, asynchronous flags kept.
// - One interrupt line; role, supply, exchange, supply error, bconn, timeout, line resume, host resume, line suspend sources.
// - Any asserted enabled interrupt is presented while unfrozen; frozen presents only asynchronous sources.
// - Frozen: configuration and buffer RAM stay accessible, bus transfers halt.
// - Frozen: only role pin, supply, line resume, host resume may interrupt.
// - Device role: bus suspend sets line suspend flag and suspends transceiver.
// - Device role: low speed force selects D- or D+ pull-up on attach.
// - Host role: pull-downs on both lines, detected speed in status field.
// - Allocating index n inserts its window; window n+1 shifts up.
// - Disabling an index keeps its allocate bit and configuration.
// - Freeing index n; window n+1 shifts down, later windows fixed.
// - Free then reallocate identically changes only that index pointer.
// - Valid flag only when size and banks fit maxima and total RAM.
// - 960-byte RAM; index 0 one bank 64; 1-4 64; 5-6 256, two banks.
module ugc_general_ctrl
  import ugc_pkg::*;
#(
  parameter int NEP = NUM_EP
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire ugc_req_t     busReq,
  output logic [31:0]       rdData,
  input  wire logic         rolePin,
  input  wire logic         supplyPin,
  input  wire ugc_core_ev_t coreEv,
  output logic              usbIrq,
  output logic              devRoleActive,
  output logic              hostRoleActive,
  output logic              coreRun,
  output logic              padSuspend,
  output logic              pullUpDp,
  output logic              pullUpDm,
  output logic              pullDownBoth,
  output logic              supplySwitch,
  output logic [10:0]       winBase [NEP],
  output logic [10:0]       winSize [NEP]
);

  // ===========================================================
  // State
  typedef struct packed {
    logic [1:0]        roleSync;
    logic [1:0]        supSync;
    logic              roleBit;
    logic              supBit;
    logic [6:0]        ctl;
    logic              disconnect_bit;
    logic [NUM_EV-1:0] irqFlag;
    logic [NUM_EV-1:0] irqEn;
    ugc_mode_t         mode;
    logic              xcvrSusp;
    logic [1:0]        speed;
    logic [NEP-1:0][6:0]  epCfg;
    logic [NEP-1:0]       epEna;
    logic [NEP-1:0]       config_valid_flag;
    logic [NEP-1:0][10:0] base;
    logic [NEP-1:0][10:0] size;
    logic [31:0]       rd;
  } ugc_state_t;

  ugc_state_t state_ff;
  ugc_state_t nxt_state;

  logic enabled;
  logic frozen;
  logic roleIsDev;
  assign enabled   = state_ff.ctl[CTL_EN];
  assign frozen    = state_ff.ctl[CTL_FRZ];
  // Pin select chooses pin or software role bit
  assign roleIsDev = state_ff.ctl[CTL_IDSEL] ? state_ff.roleBit : state_ff.ctl[CTL_SWROL];

  // ===========================================================
  // Next-state logic
  always_comb begin
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] clr;
    logic [10:0]       bytesNeeded;
    logic [10:0]       top;
    int                idx;
    ev          = '0;
    clr         = '0;
    bytesNeeded = '0;
    top         = '0;
    idx         = 0;
    nxt_state   = state_ff;
    nxt_state.rd = 32'h0;

    // Pin synchronisers, status tracks pins in any state
    nxt_state.roleSync = {state_ff.roleSync[0], rolePin};
    nxt_state.supSync  = {state_ff.supSync[0], supplyPin};
    nxt_state.roleBit  = state_ff.roleSync[1];
    nxt_state.supBit   = state_ff.supSync[1];

    // Event sources
    ev[EV_ID]  = state_ff.roleBit != state_ff.roleSync[1];
    ev[EV_SUP] = state_ff.supBit != state_ff.supSync[1];
    if (enabled && !frozen) begin
      ev[EV_ROLE]  = coreEv.roleExch;
      ev[EV_SERR]  = coreEv.supplyErr;
      ev[EV_BCERR] = coreEv.bconnErr;
      ev[EV_STO]   = coreEv.suspTimeout;
      ev[EV_LINE_SUSPEND_IRQ]  = coreEv.busSuspend && state_ff.mode == UGC_DEV;
    end
    if (enabled) begin
      ev[EV_WAKE] = coreEv.lineResume;
      ev[EV_HWUP] = coreEv.hostResume;
    end

    // Bus writes
    if (busReq.wr) begin
      unique case (busReq.addr)
        GEN_CTRL_OFS:   nxt_state.ctl = busReq.wdata[6:0];
        GEN_IRQEN_OFS:  nxt_state.irqEn = busReq.wdata[NUM_EV-1:0];
        GEN_IRQCLR_OFS: clr = busReq.wdata[NUM_EV-1:0];
        DEV_CTRL_OFS:   nxt_state.disconnect_bit = busReq.wdata[DEV_DISCONNECT_BIT];
        EP_ENA_OFS:     nxt_state.epEna = busReq.wdata[NEP-1:0];
        default: begin
          if (busReq.addr >= EP_CFG_BASE && busReq.addr < EP_CFG_BASE + 8'(4 * NEP)) begin
            idx = int'(busReq.addr[7:2]) - int'(EP_CFG_BASE[7:2]);
            nxt_state.epCfg[idx] = busReq.wdata[6:0];
          end
        end
      endcase
    end

    // Sticky flags: set wins over clear
    nxt_state.irqFlag = (state_ff.irqFlag & ~clr) | ev;
    // Line suspend parks the transceiver; resume or attach wakes it
    if (ev[EV_LINE_SUSPEND_IRQ]) begin
      nxt_state.xcvrSusp = 1'b1;
    end else if (coreEv.lineResume || state_ff.disconnect_bit) begin
      nxt_state.xcvrSusp = nxt_state.disconnect_bit;
    end

    // Role tracking while running
    if (!enabled) begin
      nxt_state.mode = UGC_OFF;
    end else begin
      nxt_state.mode = roleIsDev ? UGC_DEV : UGC_HOST;
    end
    if (state_ff.mode == UGC_HOST && !frozen) begin
      nxt_state.speed = coreEv.speedDet;
    end

    // Allocator: window of n packed after n-1; n+1 follows n, n+2 on fixed
    for (int n = 0; n < NEP; n++) begin
      logic allocNew;
      logic freeNew;
      allocNew = nxt_state.epCfg[n][CFG_MEMORY_ALLOCATE_BIT] && !state_ff.epCfg[n][CFG_MEMORY_ALLOCATE_BIT];
      freeNew  = !nxt_state.epCfg[n][CFG_MEMORY_ALLOCATE_BIT] && state_ff.epCfg[n][CFG_MEMORY_ALLOCATE_BIT];
      bytesNeeded = ugc_size_bytes(nxt_state.epCfg[n][CFG_SZ_HI:CFG_SZ_LO])
                    << nxt_state.epCfg[n][CFG_BK];
      top = (n == 0) ? 11'd0 : state_ff.base[n-1] + state_ff.size[n-1];
      if (allocNew) begin
        nxt_state.base[n] = top;
        nxt_state.size[n] = bytesNeeded;
        nxt_state.config_valid_flag[n] = (ugc_size_bytes(nxt_state.epCfg[n][CFG_SZ_HI:CFG_SZ_LO])
                              <= 11'(ugc_max_size(n)))
                             && !(n == 0 && nxt_state.epCfg[n][CFG_BK])
                             && (bytesNeeded <= RAM_BYTES);
        if (n + 1 < NEP && state_ff.epCfg[n+1][CFG_MEMORY_ALLOCATE_BIT]) begin
          nxt_state.base[n+1] = top + bytesNeeded;
        end
      end else if (freeNew) begin
        nxt_state.size[n]  = 11'd0;
        nxt_state.config_valid_flag[n] = 1'b0;
        if (n + 1 < NEP && state_ff.epCfg[n+1][CFG_MEMORY_ALLOCATE_BIT]) begin
          nxt_state.base[n+1] = state_ff.base[n];
        end
      end
    end

    // Register reads, answered next cycle
    if (busReq.rd) begin
      unique case (busReq.addr)
        GEN_CTRL_OFS:   nxt_state.rd = {25'h0, state_ff.ctl};
        GEN_STAT_OFS:   nxt_state.rd = {19'h0, state_ff.speed, state_ff.supBit,
                                        state_ff.roleBit, state_ff.irqFlag};
        GEN_IRQEN_OFS:  nxt_state.rd = {23'h0, state_ff.irqEn};
        DEV_CTRL_OFS:   nxt_state.rd = {31'h0, state_ff.disconnect_bit};
        EP_ENA_OFS:     nxt_state.rd = 32'(state_ff.epEna);
        default: begin
          if (busReq.addr >= EP_CFG_BASE && busReq.addr < EP_CFG_BASE + 8'(4 * NEP)) begin
            idx = int'(busReq.addr[7:2]) - int'(EP_CFG_BASE[7:2]);
            nxt_state.rd = {25'h0, state_ff.epCfg[idx]};
          end else if (busReq.addr >= EP_STAT_BASE &&
                       busReq.addr < EP_STAT_BASE + 8'(4 * NEP)) begin
            idx = int'(busReq.addr[7:2]) - int'(EP_STAT_BASE[7:2]);
            nxt_state.rd = {state_ff.size[idx], 5'h0, state_ff.base[idx],
                            4'h0, state_ff.config_valid_flag[idx]};
          end
        end
      endcase
    end

    // Disable acts as reset; control bits and RAM survive, endpoint configuration cleared
    if (!enabled && !nxt_state.ctl[CTL_EN]) begin
      nxt_state.disconnect_bit   = DISCONNECT_BIT_RESET;
      nxt_state.irqFlag  = nxt_state.irqFlag & ASYNC_EV_MASK;
      nxt_state.xcvrSusp = 1'b1;
      nxt_state.speed    = 2'h0;
      nxt_state.epCfg    = '0;
      nxt_state.epEna    = '0;
      nxt_state.config_valid_flag    = '0;
      nxt_state.base     = '0;
      nxt_state.size     = '0;
    end
  end

  // ===========================================================
  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff          <= '0;
      state_ff.roleSync <= {2{ROLE_IDLE}}; // Pin idles high, no false edge
      state_ff.roleBit  <= ROLE_IDLE;
      state_ff.ctl      <= CTL_RESET;
      state_ff.disconnect_bit   <= DISCONNECT_BIT_RESET;
      state_ff.mode     <= UGC_OFF;
      state_ff.xcvrSusp <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ===========================================================
  // Outputs; freeze masks all but asynchronous sources
  assign usbIrq = |(state_ff.irqFlag & state_ff.irqEn &
                    (frozen ? ASYNC_EV_MASK : {NUM_EV{1'b1}}));
  assign rdData         = state_ff.rd;
  assign devRoleActive  = state_ff.mode == UGC_DEV;
  assign hostRoleActive = state_ff.mode == UGC_HOST;
  assign coreRun        = enabled && !frozen;
  assign padSuspend     = !coreRun || state_ff.xcvrSusp || !state_ff.ctl[CTL_PADE];
  assign pullUpDp = devRoleActive && !state_ff.disconnect_bit && !state_ff.ctl[CTL_LS];
  assign pullUpDm = devRoleActive && !state_ff.disconnect_bit && state_ff.ctl[CTL_LS];
  assign pullDownBoth = hostRoleActive;
  assign supplySwitch = hostRoleActive ^ state_ff.ctl[CTL_VPOL];

  for (genvar g = 0; g < NEP; g++) begin : g_win
    assign winBase[g] = state_ff.base[g];
    assign winSize[g] = state_ff.size[g];
  end

  // ===========================================================
  // Checks
  property p_disable_clears;
    @(posedge clk) disable iff (!rst_b)
      !enabled |=> state_ff.mode == UGC_OFF;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("mode not off");

  property p_role_follow;
    @(posedge clk) disable iff (!rst_b)
      enabled && state_ff.ctl[CTL_IDSEL] && !state_ff.roleBit |=> state_ff.mode == UGC_HOST;
  endproperty
  a_role_follow: assert property (p_role_follow) else $error("host role missed");

  property p_frozen_mask;
    @(posedge clk) disable iff (!rst_b)
      frozen && usbIrq |-> |(state_ff.irqFlag & state_ff.irqEn & ASYNC_EV_MASK);
  endproperty
  a_frozen_mask: assert property (p_frozen_mask) else $error("sync irq while frozen");

  property p_irq_present;
    @(posedge clk) disable iff (!rst_b)
      !frozen && |(state_ff.irqFlag & state_ff.irqEn) |-> usbIrq;
  endproperty
  a_irq_present: assert property (p_irq_present) else $error("irq not shown");

  sequence ev_line_suspend_irq_seq;
    enabled && !frozen && coreEv.busSuspend && state_ff.mode == UGC_DEV;
  endsequence
  property p_line_suspend_irq_xcvr;
    @(posedge clk) disable iff (!rst_b)
      ev_line_suspend_irq_seq |=> state_ff.xcvrSusp && state_ff.irqFlag[EV_LINE_SUSPEND_IRQ];
  endproperty
  a_line_suspend_irq_xcvr: assert property (p_line_suspend_irq_xcvr) else $error("suspend not taken");

  property p_pullups;
    @(posedge clk) disable iff (!rst_b)
      !(pullUpDp && pullUpDm) && !(pullDownBoth && (pullUpDp || pullUpDm));
  endproperty
  a_pullups: assert property (p_pullups) else $error("pull conflict");

  property p_cfg_keep;
    @(posedge clk) disable iff (!rst_b)
      enabled && busReq.wr && busReq.addr == EP_ENA_OFS |=> state_ff.epCfg == $past(state_ff.epCfg);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("config lost");

  property p_ok_bound;
    @(posedge clk) disable iff (!rst_b)
      state_ff.config_valid_flag[0] |-> state_ff.size[0] <= 11'd64;
  endproperty
  a_ok_bound: assert property (p_ok_bound) else $error("index 0 oversize ok");

  property p_disable_reset;
    @(posedge clk) disable iff (!rst_b)
      enabled ##1 !enabled |=> state_ff.epCfg == '0 && state_ff.disconnect_bit;
  endproperty
  a_disable_reset: assert property (p_disable_reset) else $error("disable no reset");

  // Status bits lag their pins by the two sync stages plus the status flop
  property p_pin_track;
    @(posedge clk) disable iff (!rst_b)
      state_ff.roleBit == $past(rolePin, 3) && state_ff.supBit == $past(supplyPin, 3);
  endproperty
  a_pin_track: assert property (p_pin_track) else $error("pin status lag");

  property p_enable_role;
    @(posedge clk) disable iff (!rst_b)
      $rose(enabled) |=> devRoleActive || hostRoleActive;
  endproperty
  a_enable_role: assert property (p_enable_role) else $error("no role after enable");

  property p_speed_hold;
    @(posedge clk) disable iff (!rst_b)
      enabled && hostRoleActive && !frozen |=> state_ff.speed == $past(coreEv.speedDet);
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("speed not reported");

  property p_frozen_halt;
    @(posedge clk) disable iff (!rst_b)
      frozen && enabled |-> !coreRun ##1 state_ff.speed == $past(state_ff.speed);
  endproperty
  a_frozen_halt: assert property (p_frozen_halt) else $error("frozen core moved");

  property p_ok_top;
    @(posedge clk) disable iff (!rst_b)
      state_ff.config_valid_flag[NEP-1] |-> state_ff.size[NEP-1] <= 11'd512;
  endproperty
  a_ok_top: assert property (p_ok_top) else $error("top index oversize ok");

endmodule

// [test/ugc_usb_peer.sv]
`timescale 1ns/1ps
// ==========================================================
// Cable peer: role plug, supply and engine events
module ugc_usb_peer
  import ugc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       plugHost,
  input  wire logic       stoReq,
  input  wire logic [1:0] speedCode,
  input  wire logic       suspReq,
  input  wire logic       supplyOn,
  output logic            rolePin,
  output logic            supplyPin,
  output ugc_core_ev_t    coreEv
);
  // Pin sits at its pull-up unless an A plug grounds it
  assign rolePin   = !plugHost;
  assign supplyPin = supplyOn;
  // Events leave registered, following their request inputs one cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coreEv <= '0;
    end else begin
      coreEv             <= '0;
      coreEv.suspTimeout <= stoReq;
      coreEv.busSuspend  <= suspReq;
      coreEv.speedDet    <= speedCode;
    end
  end
endmodule

// [test/usb_general_control_dpram_memory_allocate_bit_tb.sv]
`timescale 1ns/1ps
module usb_general_control_dpram_memory_allocate_bit_tb;
  import ugc_pkg::*;
  logic         clk;
  logic         rst_b;
  ugc_req_t     busReq;
  logic [31:0]  rdData;
  logic         rolePin;
  logic         supplyPin;
  ugc_core_ev_t coreEv;
  logic         usbIrq;
  logic         devRoleActive;
  logic         hostRoleActive;
  logic         coreRun;
  logic         padSuspend;
  logic         pullUpDp;
  logic         pullUpDm;
  logic         pullDownBoth;
  logic         supplySwitch;
  logic [10:0]  winBase [NUM_EP];
  logic [10:0]  winSize [NUM_EP];
  logic         plugHost;
  logic         stoReq;
  logic [1:0]   speedCode;
  logic         suspReq;
  logic         supplyOn;
  logic [31:0]  rv;
  int           errTotal;
  int           comparisons;

  ugc_general_ctrl dut (.clk(clk), .rst_b(rst_b), .busReq(busReq), .rdData(rdData),
    .rolePin(rolePin), .supplyPin(supplyPin), .coreEv(coreEv), .usbIrq(usbIrq),
    .devRoleActive(devRoleActive), .hostRoleActive(hostRoleActive), .coreRun(coreRun),
    .padSuspend(padSuspend), .pullUpDp(pullUpDp), .pullUpDm(pullUpDm),
    .pullDownBoth(pullDownBoth), .supplySwitch(supplySwitch), .winBase(winBase),
    .winSize(winSize));
  ugc_usb_peer peer (.clk(clk), .rst_b(rst_b), .plugHost(plugHost), .stoReq(stoReq),
    .speedCode(speedCode), .suspReq(suspReq), .supplyOn(supplyOn), .rolePin(rolePin),
    .supplyPin(supplyPin), .coreEv(coreEv));

  // ==========================================================
  // Bus and check helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    busReq.addr  <= a;
    busReq.wdata <= d;
    busReq.wr    <= 1'b1;
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    busReq.addr <= a;
    busReq.rd   <= 1'b1;
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    d = rdData;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait so a dead interrupt cannot hang the run
  task automatic wait_irq();
    for (int i = 0; i < 20 && usbIrq !== 1'b1; i++) @(posedge clk);
    if (usbIrq !== 1'b1) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, usbIrq, 1'b1);
      test_done();
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, errors %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_reg(GEN_CTRL_OFS, rv);
    chk(rv, 32'h0000_0034);
    rd_reg(GEN_STAT_OFS, rv);
    chk({21'h0, rv[10:0]}, 32'h200);
    chk({28'h0, devRoleActive, hostRoleActive, coreRun, padSuspend}, 32'h1);
    rd_reg(8'hfc, rv);
    chk(rv, 32'h0);
    // Low speed and unfreeze staged while still disabled
    wr_reg(GEN_CTRL_OFS, 32'h71);
    rd_reg(GEN_CTRL_OFS, rv);
    chk(rv, 32'h71);
    chk({30'h0, pullUpDm, coreRun}, 32'h0);
  endtask
  task automatic t_enable();
    wr_reg(GEN_CTRL_OFS, 32'h79);
    settle(2);
    chk({30'h0, devRoleActive, coreRun}, 32'h3);
    wr_reg(DEV_CTRL_OFS, 32'h0);
    settle(2);
    chk({29'h0, padSuspend, pullUpDm, pullUpDp}, 32'h2);
    wr_reg(GEN_CTRL_OFS, 32'h39);
    settle(2);
    chk({30'h0, pullUpDm, pullUpDp}, 32'h1);
  endtask
  // Bus suspend parks the pad; a supply rise raises its flag and status
  task automatic t_suspend_supply();
    @(posedge clk);
    suspReq  <= 1'b1;
    supplyOn <= 1'b1;
    @(posedge clk);
    suspReq <= 1'b0;
    settle(4);
    chk({31'h0, padSuspend}, 32'h1);
    rd_reg(GEN_STAT_OFS, rv);
    chk({29'h0, rv[10], rv[8], rv[1]}, 32'h7);
  endtask
  task automatic t_memory_allocate_bit();
    logic [7:0]  idx [4] = '{8'd3, 8'd4, 8'd5, 8'd6};
    logic [31:0] cfg [4] = '{32'h41, 32'h33, 32'h51, 32'h61};
    logic        ok  [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr_reg(EP_ENA_OFS, 32'h7f);
    wr_reg(EP_CFG_BASE, 32'h31);
    wr_reg(EP_CFG_BASE + 8'h04, 32'h31);
    wr_reg(EP_CFG_BASE + 8'h08, 32'h31);
    settle(1);
    chk({21'h0, winBase[1]}, 32'd64);
    chk({21'h0, winBase[2]}, 32'd128);
    rd_reg(EP_STAT_BASE + 8'h04, rv);
    chk(rv & 32'hffe0_ffe1, 32'h0800_0801);
    wr_reg(EP_ENA_OFS, 32'h7d);
    rd_reg(EP_CFG_BASE + 8'h04, rv);
    chk(rv[7:0], 32'h31);
    wr_reg(EP_CFG_BASE, 32'h30);
    settle(1);
    chk({winBase[1], winBase[2]}, {11'd0, 11'd128});
    wr_reg(EP_CFG_BASE, 32'h31);
    settle(1);
    chk({winBase[0], winBase[1]}, {11'd0, 11'd64});
    // Size and bank limits per index, in ascending order
    for (int i = 0; i < 4; i++) begin
      wr_reg(EP_CFG_BASE + 8'h04 * idx[i], cfg[i]);
      rd_reg(EP_STAT_BASE + 8'h04 * idx[i], rv);
      chk(rv[0], ok[i]);
    end
    wr_reg(EP_CFG_BASE, 32'h30);
    wr_reg(EP_CFG_BASE, 32'h33);
    rd_reg(EP_STAT_BASE, rv);
    chk(rv[0], 32'h0);
  endtask
  task automatic t_irq_freeze();
    wr_reg(GEN_IRQEN_OFS, 32'h21);
    @(posedge clk);
    stoReq <= 1'b1;
    @(posedge clk);
    stoReq <= 1'b0;
    wait_irq();
    // Endpoints idled so no DMA traffic runs into sleep
    wr_reg(EP_ENA_OFS, 32'h0);
    wr_reg(GEN_CTRL_OFS, 32'h3d);
    settle(1);
    chk({30'h0, usbIrq, coreRun}, 32'h0);
    rd_reg(GEN_CTRL_OFS, rv);
    chk(rv, 32'h3d);
    wr_reg(GEN_IRQCLR_OFS, 32'h20);
    // Plug swap while frozen must still wake the processor
    plugHost <= 1'b1;
    wait_irq();
    wr_reg(GEN_CTRL_OFS, 32'h39);
    settle(2);
    chk({29'h0, devRoleActive, hostRoleActive, pullDownBoth}, 32'h3);
    rd_reg(GEN_STAT_OFS, rv);
    chk({rv[12:11], rv[9], rv[0]}, 32'h5);
  endtask
  task automatic t_disable();
    wr_reg(GEN_CTRL_OFS, 32'h31);
    settle(2);
    rd_reg(GEN_CTRL_OFS, rv);
    chk(rv, 32'h31);
    chk({29'h0, hostRoleActive, coreRun, padSuspend}, 32'h1);
    rd_reg(EP_STAT_BASE + 8'h04, rv);
    chk(rv[0], 32'h0);
  endtask

  // ==========================================================
  // Clock, reset and sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_b       = 1'b0;
    busReq      = '0;
    plugHost    = 1'b0;
    stoReq      = 1'b0;
    speedCode   = 2'b01;
    suspReq     = 1'b0;
    supplyOn    = 1'b0;
    errTotal    = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_enable();
    t_suspend_supply();
    t_memory_allocate_bit();
    t_irq_freeze();
    t_disable();
    test_done();
  end
  // Whole-run limit, far above the run's length
  initial begin
    #400000;
    errTotal++;
    test_done();
  end
endmodule
